/* File: verilog/cir_pkg.sv */
package cir_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned MS_CYC = CLK_HZ / 1000;
    localparam int unsigned FLASH_HALF_MS = 250;
    localparam int unsigned ACT_HOLD_MS = 50;
    localparam int unsigned TRIG_HOLD_MS = 1000;
    localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * MS_CYC;
    localparam int unsigned ACT_HOLD_CYC = ACT_HOLD_MS * MS_CYC;
    localparam int unsigned TRIG_HOLD_CYC = TRIG_HOLD_MS * MS_CYC;
    localparam int unsigned HOLD_W = 26;

    localparam int unsigned NUM_OUT = 4;
    localparam int unsigned NUM_IN = 4;
    localparam int unsigned LINE_CNT = 8;
    localparam int unsigned SEL_W = 3;
    localparam int unsigned SRC_W = 4;

    localparam logic [7:0] REG_LINE_SEL = 8'h00;
    localparam logic [7:0] REG_INVERT = 8'h04;
    localparam logic [7:0] REG_SOURCE = 8'h08;
    localparam logic [7:0] REG_USER_OUT = 8'h0C;
    localparam logic [7:0] REG_LINE_STATUS = 8'h10;
    localparam logic [7:0] REG_TRIG_CTRL = 8'h14;
    localparam logic [7:0] REG_LINK_STATUS = 8'h18;

    localparam int unsigned STAT_LEVEL_BIT = 0;
    localparam int unsigned STAT_DIR_BIT = 1;
    localparam int unsigned STAT_TYPE_LSB = 2;
    localparam int unsigned STAT_ALL_LSB = 8;
    localparam int unsigned TRIG_ACT_BIT = 0;
    localparam int unsigned TRIG_LINE_LSB = 4;
    localparam int unsigned LINK_STREAM_BIT = 2;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ETYPE_TTL = 2'b00,
        ETYPE_OPTO = 2'b01,
        ETYPE_LVDS = 2'b10
    } cir_etype_e;

    typedef enum logic [3:0] {
        SRC_ACQ_TRIG_WAIT = 4'h0,
        SRC_ACQ_ACTIVE = 4'h1,
        SRC_FRAME_TRIG_WAIT = 4'h2,
        SRC_FRAME_ACTIVE = 4'h3,
        SRC_EXPOSURE = 4'h4,
        SRC_VENDOR_ACQ_WAIT = 4'h5,
        SRC_COUNTER_ONE = 4'h6,
        SRC_TIMER_ONE = 4'h7,
        SRC_USER0 = 4'h8,
        SRC_USER1 = 4'h9,
        SRC_USER2 = 4'hA,
        SRC_USER3 = 4'hB
    } cir_source_e;

    typedef enum logic [1:0] {
        LINK_DOWN = 2'b00,
        LINK_10 = 2'b01,
        LINK_100 = 2'b10,
        LINK_1000 = 2'b11
    } cir_speed_e;

    typedef struct packed {
        logic acq_trig_wait_sig;
        logic acq_active_sig;
        logic frame_trig_wait_sig;
        logic frame_active_sig;
        logic exposure_window_sig;
        logic vendor_acq_wait_sig;
        logic counter_one_busy_sig;
        logic timer_one_busy_sig;
    } cir_timing_s;
endpackage

/* File: verilog/cir_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module cir_sync2 #(
    parameter int unsigned W = 4
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Data.
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stage1 <= '0;
            q_o <= '0;
        end
        else
        begin
            stage1 <= d_i;
            q_o <= stage1;
        end
    end
endmodule // cir_sync2
`default_nettype wire

/* File: verilog/cir_blink.sv */
`timescale 1ns/1ps
`default_nettype none
module cir_blink
    import cir_pkg::*;
#(
    parameter int unsigned HALF_CYC = FLASH_HALF_CYC
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Square wave used for flashing indicators.
    output logic phase_o
);
    logic [HOLD_W-1:0] count;
    logic [HOLD_W-1:0] next_count;
    logic next_phase;

    always_comb
    begin
        next_count = count + HOLD_W'(1);
        next_phase = phase_o;
        if (count >= HOLD_W'(HALF_CYC - 1))
        begin
            next_count = '0;
            next_phase = !phase_o;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count <= '0;
            phase_o <= 1'b0;
        end
        else
        begin
            count <= next_count;
            phase_o <= next_phase;
        end
    end
endmodule // cir_blink
`default_nettype wire

/* File: verilog/cir_line_router.sv */
// Behaviour
// R1: Eight lines; one to four out, rest in.
// R2: Report TTL, opto or LVDS per line.
// R3: Per-line inversion flips signal polarity.
// R4: Software reads selected line level.
// R5: Outputs one to four pick their source.
// R6: Twelve sources: timing signals and user bits.
// R7: Report whether selected line is input/output.
// R8: Rear LED amber, steady or flashing green.
// R9: Link LED steady green at 1000.
// R10: Slower link flashes green, no streaming.
// R11: Link indicator flashes amber on traffic.
// R12: Both trigger edges count; polarity selectable.
// R13: Reset clears inversion, sets default sources.
`timescale 1ns/1ps
`default_nettype none
module cir_line_router
    import cir_pkg::*;
#(
    parameter int unsigned FLASH_CYC = FLASH_HALF_CYC,
    parameter int unsigned ACT_CYC = ACT_HOLD_CYC,
    parameter int unsigned TRIG_CYC = TRIG_HOLD_CYC
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // AXI4-Lite slave.
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Internal camera state.
    input wire cir_timing_s timing_i,
    input wire logic init_busy_i,
    input wire logic continuous_mode_i,
    input wire logic [1:0] link_speed_i,
    input wire logic link_activity_i,
    // Lines.
    output logic [NUM_OUT-1:0] out_line_o,
    input wire logic [NUM_IN-1:0] in_line_i,
    // Trigger.
    output logic trig_event_o,
    output logic trig_level_o,
    // Indicators and link control.
    output logic status_led_amber_o,
    output logic status_led_green_o,
    output logic link_led_green_o,
    output logic link_led_amber_o,
    output logic stream_enable_o
);
    function automatic logic is_output(input logic [SEL_W-1:0] sel);
        return sel < SEL_W'(NUM_OUT);
    endfunction

    function automatic logic [1:0] elec_type(input logic [SEL_W-1:0] sel);
        unique case (sel)
            3'd0, 3'd1, 3'd6: return ETYPE_TTL; // R2
            3'd7: return ETYPE_LVDS; // R2
            default: return ETYPE_OPTO; // R2
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    logic [SEL_W-1:0] line_select;
    logic [LINE_CNT-1:0] line_polarity_flip;
    logic [NUM_OUT-1:0][SRC_W-1:0] output_source_select;
    logic [NUM_OUT-1:0] sw_output_bits;
    logic trig_act;
    logic [1:0] trig_line;
    logic [SEL_W-1:0] next_line_select;
    logic [LINE_CNT-1:0] next_flip;
    logic [NUM_OUT-1:0][SRC_W-1:0] next_source;
    logic [NUM_OUT-1:0] next_sw_bits;
    logic next_trig_act;
    logic [1:0] next_trig_line;

    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data, next_rdata;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp, next_rresp;
    logic do_write;

    logic [NUM_IN-1:0] in_sync;
    logic [NUM_IN-1:0] in_level;
    logic [LINE_CNT-1:0] line_level_readback;
    logic sel_level;
    logic [NUM_OUT-1:0] next_out;
    logic [NUM_OUT-1:0] src_level;

    logic trig_src, trig_prev, next_trig_event;
    logic [HOLD_W-1:0] trig_hold, act_hold, next_trig_hold, next_act_hold;
    logic blink;
    logic next_st_amber, next_st_green, next_lk_green, next_lk_amber, next_stream;

    cir_sync2 #(.W(NUM_IN)) u_in_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(in_line_i),
        .q_o(in_sync)
    );

    cir_blink #(.HALF_CYC(FLASH_CYC)) u_blink (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .phase_o(blink)
    );

    // A write completes once address and data are both held and no response is pending.
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    assign in_level = in_sync ^ line_polarity_flip[LINE_CNT-1:NUM_OUT]; // R3
    assign line_level_readback = {in_level, out_line_o}; // R1 R4
    assign sel_level = line_level_readback[line_select]; // R4

    always_comb
    begin
        for (int i = 0; i < NUM_OUT; i++)
        begin
            unique case (output_source_select[i]) // R6
                SRC_ACQ_TRIG_WAIT: src_level[i] = timing_i.acq_trig_wait_sig;
                SRC_ACQ_ACTIVE: src_level[i] = timing_i.acq_active_sig;
                SRC_FRAME_TRIG_WAIT: src_level[i] = timing_i.frame_trig_wait_sig;
                SRC_FRAME_ACTIVE: src_level[i] = timing_i.frame_active_sig;
                SRC_EXPOSURE: src_level[i] = timing_i.exposure_window_sig;
                SRC_VENDOR_ACQ_WAIT: src_level[i] = timing_i.vendor_acq_wait_sig;
                SRC_COUNTER_ONE: src_level[i] = timing_i.counter_one_busy_sig;
                SRC_TIMER_ONE: src_level[i] = timing_i.timer_one_busy_sig;
                SRC_USER0: src_level[i] = sw_output_bits[0];
                SRC_USER1: src_level[i] = sw_output_bits[1];
                SRC_USER2: src_level[i] = sw_output_bits[2];
                SRC_USER3: src_level[i] = sw_output_bits[3];
                default: src_level[i] = 1'b0;
            endcase
        end
        next_out = src_level ^ line_polarity_flip[NUM_OUT-1:0]; // R5 R3
    end

    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_line_select = line_select;
        next_flip = line_polarity_flip;
        next_source = output_source_select;
        next_sw_bits = sw_output_bits;
        next_trig_act = trig_act;
        next_trig_line = trig_line;
        if (s_axi_awvalid && !aw_held)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !w_held)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            unique case (aw_addr)
                REG_LINE_SEL: next_line_select =
                    SEL_W'(merge(32'(line_select), w_data, w_strb)); // R1
                REG_INVERT: next_flip =
                    LINE_CNT'(merge(32'(line_polarity_flip), w_data, w_strb)); // R3
                REG_SOURCE: next_source =
                    (NUM_OUT * SRC_W)'(merge(32'(output_source_select), w_data, w_strb)); // R5
                REG_USER_OUT: next_sw_bits =
                    NUM_OUT'(merge(32'(sw_output_bits), w_data, w_strb)); // R6
                REG_TRIG_CTRL:
                begin
                    next_trig_act = w_strb[0] ? w_data[TRIG_ACT_BIT] : trig_act; // R12
                    next_trig_line = w_strb[0] ? w_data[TRIG_LINE_LSB +: 2] : trig_line;
                end
                REG_LINE_STATUS, REG_LINK_STATUS: next_bresp = RESP_OKAY;
                default: next_bresp = RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && !s_axi_rvalid)
        begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = '0;
            unique case (s_axi_araddr[7:0])
                REG_LINE_SEL: next_rdata[SEL_W-1:0] = line_select;
                REG_INVERT: next_rdata[LINE_CNT-1:0] = line_polarity_flip;
                REG_SOURCE: next_rdata[15:0] = output_source_select;
                REG_USER_OUT: next_rdata[NUM_OUT-1:0] = sw_output_bits;
                REG_LINE_STATUS:
                begin
                    next_rdata[STAT_LEVEL_BIT] = sel_level; // R4
                    next_rdata[STAT_DIR_BIT] = is_output(line_select); // R7
                    next_rdata[STAT_TYPE_LSB +: 2] = elec_type(line_select); // R2
                    next_rdata[STAT_ALL_LSB +: LINE_CNT] = line_level_readback;
                end
                REG_TRIG_CTRL:
                begin
                    next_rdata[TRIG_ACT_BIT] = trig_act;
                    next_rdata[TRIG_LINE_LSB +: 2] = trig_line;
                end
                REG_LINK_STATUS:
                begin
                    next_rdata[1:0] = link_speed_i;
                    next_rdata[LINK_STREAM_BIT] = stream_enable_o;
                end
                default: next_rresp = RESP_SLVERR;
            endcase
        end
    end

    // Both edges of the chosen input are events; activation sets the active level.
    always_comb
    begin
        trig_src = in_level[trig_line] ^ trig_act; // R12
        next_trig_event = trig_src != trig_prev; // R12
        next_trig_hold = (trig_hold != '0) ? trig_hold - HOLD_W'(1) : '0;
        if (next_trig_event)
        begin
            next_trig_hold = HOLD_W'(TRIG_CYC);
        end
        next_act_hold = (act_hold != '0) ? act_hold - HOLD_W'(1) : '0;
        if (link_activity_i)
        begin
            next_act_hold = HOLD_W'(ACT_CYC);
        end
        next_st_amber = init_busy_i; // R8
        next_st_green = !init_busy_i &&
            ((trig_hold != '0) ? blink : continuous_mode_i); // R8
        next_stream = link_speed_i == LINK_1000; // R10
        next_lk_green = next_stream || (link_speed_i != LINK_DOWN && blink); // R9 R10
        next_lk_amber = (act_hold != '0) && blink; // R11
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
            line_select <= '0;
            line_polarity_flip <= '0; // R13
            output_source_select <= {NUM_OUT{SRC_USER0}}; // R13
            sw_output_bits <= '0; // R13
            trig_act <= 1'b0;
            trig_line <= '0;
            out_line_o <= '0;
            trig_prev <= 1'b0;
            trig_event_o <= 1'b0;
            trig_level_o <= 1'b0;
            trig_hold <= '0;
            act_hold <= '0;
            status_led_amber_o <= 1'b1;
            status_led_green_o <= 1'b0;
            link_led_green_o <= 1'b0;
            link_led_amber_o <= 1'b0;
            stream_enable_o <= 1'b0;
        end
        else
        begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            line_select <= next_line_select;
            line_polarity_flip <= next_flip;
            output_source_select <= next_source;
            sw_output_bits <= next_sw_bits;
            trig_act <= next_trig_act;
            trig_line <= next_trig_line;
            out_line_o <= next_out;
            trig_prev <= trig_src;
            trig_event_o <= next_trig_event;
            trig_level_o <= trig_src;
            trig_hold <= next_trig_hold;
            act_hold <= next_act_hold;
            status_led_amber_o <= next_st_amber;
            status_led_green_o <= next_st_green;
            link_led_green_o <= next_lk_green;
            link_led_amber_o <= next_lk_amber;
            stream_enable_o <= next_stream;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence status_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == REG_LINE_STATUS;
    endsequence

    sequence user0_plain_steady;
        (output_source_select[0] == SRC_USER0 && !line_polarity_flip[0]
         && $stable(sw_output_bits[0]))[*2];
    endsequence

    AST_OUT_FROM_USER: assert property (user0_plain_steady |-> // R5
        out_line_o[0] == sw_output_bits[0]) else $error("line 1 not from user bit");
    AST_OUT_FROM_EXPOSURE: assert property ( // R6
        output_source_select[1] == SRC_EXPOSURE && !line_polarity_flip[1]
        |=> out_line_o[1] == $past(timing_i.exposure_window_sig))
        else $error("line 2 not from exposure");
    AST_INPUT_INVERT: assert property ( // R3
        line_polarity_flip[4] |-> line_level_readback[4] == !$past(in_line_i[0], 2))
        else $error("line 5 inversion wrong");
    AST_LEVEL_READ: assert property (status_read |=> // R4
        s_axi_rvalid && s_axi_rdata[STAT_LEVEL_BIT] == $past(sel_level))
        else $error("selected level misreported");
    AST_DIR_READ: assert property (status_read |=> // R7
        s_axi_rdata[STAT_DIR_BIT] == ($past(line_select) < SEL_W'(NUM_OUT)))
        else $error("direction misreported");
    AST_TYPE_READ: assert property (status_read ##0 line_select == 3'd7 |=> // R2
        s_axi_rdata[STAT_TYPE_LSB +: 2] == ETYPE_LVDS) else $error("line 8 not LVDS");
    AST_LED_INIT: assert property (init_busy_i |=> // R8
        status_led_amber_o && !status_led_green_o) else $error("amber missing in init");
    AST_LINK_GIGABIT: assert property ((link_speed_i == LINK_1000)[*2] |-> // R9
        link_led_green_o && stream_enable_o) else $error("gigabit link not steady");
    AST_NO_SLOW_STREAM: assert property (link_speed_i != LINK_1000 |=> // R10
        !stream_enable_o) else $error("streaming on slow link");
    AST_AMBER_ACTIVITY: assert property (link_led_amber_o |-> // R11
        $past(act_hold) != '0) else $error("amber without traffic");
    AST_TRIG_BOTH_EDGES: assert property ($changed(trig_src) |=> // R12
        trig_event_o ##1 !trig_event_o || ($past(trig_src) != $past(trig_src, 2)))
        else $error("trigger edge missed");
endmodule // cir_line_router
`default_nettype wire

/* File: bench/cir_line_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module cir_line_partner (
    // Levels the equipment is told to present.
    input wire logic [3:0] want_i,
    // Pins of lines five to eight.
    output logic [3:0] pins_o
);
    // The equipment runs on its own time, so its edges fall between clock edges.
    // The pins start low so that the lines are defined from time zero.
    initial
    begin
        pins_o = '0;
        forever
        begin
            @(want_i);
            pins_o <= #7 want_i;
        end
    end
endmodule // cir_line_partner
`default_nettype wire

/* File: bench/cir_line_router_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cir_line_router_tb import cir_pkg::*;;
    logic clk_i = '0;
    logic rst_n_i = '0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
    logic s_axi_bready = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, link_speed_i = '0;
    cir_timing_s timing_i = '0;
    logic init_busy_i = '1, continuous_mode_i = '0, link_activity_i = '0;
    logic [3:0] out_line_o, in_line_i, want = '0, usr, e;
    logic trig_event_o, trig_level_o, status_led_amber_o, status_led_green_o;
    logic link_led_green_o, link_led_amber_o, stream_enable_o;
    logic [34:0] exp_q[$];
    logic [34:0] m;
    logic [7:0] inv;
    logic [15:0] src;
    int num_errors = 0, checks_done = 0, n, x;
    int hi[3], ch[3];
    wire logic [2:0] leds = {link_led_amber_o, link_led_green_o, status_led_green_o};

    always #25 clk_i = ~clk_i;

    cir_line_router #(.FLASH_CYC(4), .ACT_CYC(8), .TRIG_CYC(16)) u_cir_line_router (
        .clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timing_i, .init_busy_i,
        .continuous_mode_i, .link_speed_i, .link_activity_i, .out_line_o, .in_line_i,
        .trig_event_o, .trig_level_o, .status_led_amber_o, .status_led_green_o,
        .link_led_green_o, .link_led_amber_o, .stream_enable_o);

    cir_line_partner u_cir_line_partner (.want_i(want), .pins_o(in_line_i));

    task automatic check(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    // One register transfer; the response is checked by the monitor below.
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] r);
        int k;
        logic done;
        k = 0;
        @(posedge clk_i);
        exp_q.push_back({rd, r, rd ? d : 32'h0});
        s_axi_awaddr <= {24'h0, a};
        s_axi_araddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= !rd;
        s_axi_wvalid <= !rd;
        s_axi_arvalid <= rd;
        s_axi_bready <= !rd;
        s_axi_rready <= rd;
        do
        begin
            @(posedge clk_i);
            k++;
            done = rd ? s_axi_rvalid && !s_axi_arvalid
                      : s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid;
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
        end while (!done && k < 99);
        s_axi_bready <= '0;
        s_axi_rready <= '0;
        if (!done)
            num_errors++;
    endtask

    always @(posedge clk_i)
    begin
        if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready)
        begin
            m = exp_q.pop_front();
            check(m[34] ? s_axi_rdata : 32'h0, m[31:0]);
            check({30'h0, m[34] ? s_axi_rresp : s_axi_bresp}, {30'h0, m[33:32]});
        end
    end

    function automatic logic [31:0] stat(input int s, input logic [7:0] all);
        cir_etype_e t;
        t = (s == 7) ? ETYPE_LVDS : (s < 2 || s == 6) ? ETYPE_TTL : ETYPE_OPTO;
        return {16'h0, all, 4'h0, t, s < 4, all[s]};
    endfunction

    // Counts high cycles and changes of the three indicators over 12 cycles.
    task automatic watch();
        logic [2:0] p;
        hi = '{0, 0, 0};
        ch = '{0, 0, 0};
        p = leds;
        repeat (12)
        begin
            @(posedge clk_i);
            for (int k = 0; k < 3; k++)
            begin
                hi[k] += int'(leds[k] === 1'b1);
                ch[k] += int'(leds[k] !== p[k]);
            end
            p = leds;
        end
    endtask

    function automatic logic [31:0] code(input int k);
        return {29'h0, hi[k] == 12, ch[k] > 0, hi[k] > 0};
    endfunction

    initial
    begin
        #(50 * 5000);
        num_errors++;
        test_done();
    end

    initial
    begin
        void'($urandom(64371));
        cyc(8);
        rst_n_i <= '1;
        cyc(2);
        check(32'(status_led_amber_o), 32'h1);
        check(32'(out_line_o), 32'h0);
        init_busy_i <= '0;
        cyc(3);
        check(32'({status_led_amber_o, status_led_green_o}), 32'h0);
        continuous_mode_i <= '1;
        cyc(3);
        check(32'(status_led_green_o), 32'h1);
        bus(1, REG_INVERT, 32'h0, RESP_OKAY);
        bus(1, REG_SOURCE, 32'h8888, RESP_OKAY);
        bus(0, 8'h20, 32'h5, RESP_SLVERR);
        bus(1, 8'h20, 32'h0, RESP_SLVERR);
        bus(0, REG_LINE_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
        s_axi_wstrb <= 4'h0;
        bus(0, REG_USER_OUT, 32'hF, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        bus(1, REG_USER_OUT, 32'h0, RESP_OKAY);
        inv = 8'($urandom);
        want <= 4'($urandom);
        bus(0, REG_INVERT, {24'h0, inv}, RESP_OKAY);
        cyc(4);
        check(32'(out_line_o), 32'(inv[3:0]));
        for (int s = 0; s < 8; s++)
        begin
            bus(0, REG_LINE_SEL, 32'(s), RESP_OKAY);
            bus(1, REG_LINE_STATUS, stat(s, {want ^ inv[7:4], inv[3:0]}), RESP_OKAY);
        end
        for (int c = 0; c < 13; c++)
        begin
            timing_i <= 8'($urandom);
            usr = 4'($urandom);
            for (int k = 0; k < 4; k++)
                src[k*4 +: 4] = 4'((c + k) % 13);
            bus(0, REG_USER_OUT, 32'(usr), RESP_OKAY);
            bus(0, REG_SOURCE, 32'(src), RESP_OKAY);
            cyc(2);
            for (int k = 0; k < 4; k++)
            begin
                x = int'(src[k*4 +: 4]);
                e[k] = x < 8 ? timing_i[7 - x] : x < 12 ? usr[x - 8] : 1'b0;
            end
            check(32'(out_line_o ^ inv[3:0]), 32'(e));
        end
        bus(0, REG_INVERT, 32'h0, RESP_OKAY);
        want <= '0;
        cyc(8);
        for (int a = 0; a < 2; a++)
        begin
            bus(0, REG_TRIG_CTRL, 32'(a), RESP_OKAY);
            // A change of activation is itself an edge of the trigger source.
            cyc(2);
            for (int p = 1; p >= 0; p--)
            begin
                want <= {3'h0, 1'(p)};
                n = 0;
                repeat (8)
                begin
                    @(posedge clk_i);
                    n += int'(trig_event_o === 1'b1);
                end
                check(32'(n), 32'h1);
                check(32'(trig_level_o), 32'(p ^ a));
            end
        end
        watch();
        check(code(0), 32'h3);
        cyc(20);
        watch();
        check(code(0), 32'h5);
        for (int s = 0; s < 4; s++)
        begin
            link_speed_i <= 2'(s);
            cyc(3);
            bus(1, REG_LINK_STATUS, {29'h0, s == 3, 2'(s)}, RESP_OKAY);
            watch();
            check(code(1), s == 3 ? 32'h5 : s > 0 ? 32'h3 : 32'h0);
            check(32'(stream_enable_o), 32'(s == 3));
        end
        link_activity_i <= '1;
        watch();
        check(code(2), 32'h3);
        link_activity_i <= '0;
        cyc(20);
        watch();
        check(code(2), 32'h0);
        test_done();
    end
endmodule // cir_line_router_tb
`default_nettype wire
